// File: core/tcss_pkg.sv
// constants, offsets and selector encodings of the timestamp clock sync selector
package tcss_pkg;
  // clock and time base
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam logic [29:0] NS_STEP       = 30'(CLK_PERIOD_NS);
  localparam logic [29:0] NS_PER_SEC    = 30'h3b9aca00;
  localparam logic [29:0] NS_HALF_SEC   = 30'h1dcd6500;
  localparam logic [31:0] THRESH_RST    = 32'h00000254;
  // host side wait-for-lock timeout, seconds
  localparam int unsigned SYNC_TIMEOUT_S = 60;
  // reference pulse timing, milliseconds, and derived cycle counts
  localparam int unsigned MISS_MS       = 1500;
  localparam int unsigned MIN_GAP_MS    = 500;
  localparam int unsigned OUT_PULSE_MS  = 100;
  localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
  localparam int unsigned MISS_CYC      = MISS_MS * CYC_PER_MS;
  localparam int unsigned MIN_GAP_CYC   = MIN_GAP_MS * CYC_PER_MS;
  localparam int unsigned OUT_PULSE_CYC = OUT_PULSE_MS * CYC_PER_MS;
  // register byte offsets
  localparam logic [7:0] OFS_SEL       = 8'h00;
  localparam logic [7:0] OFS_CMD       = 8'h04;
  localparam logic [7:0] OFS_HOST_SEC  = 8'h08;
  localparam logic [7:0] OFS_THRESH    = 8'h0c;
  localparam logic [7:0] OFS_STATUS    = 8'h10;
  localparam logic [7:0] OFS_TOTAL     = 8'h14;
  localparam logic [7:0] OFS_BAD       = 8'h18;
  localparam logic [7:0] OFS_MISSED    = 8'h1c;
  localparam logic [7:0] OFS_FAIL      = 8'h20;
  localparam logic [7:0] OFS_RESYNC    = 8'h24;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h28;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h2c;
  localparam logic [7:0] OFS_TIME_NS   = 8'h30;
  localparam logic [7:0] OFS_TIME_SEC  = 8'h34;
  // field positions
  localparam int unsigned SEL_IN_LSB   = 0;
  localparam int unsigned SEL_OUT_LSB  = 4;
  localparam int unsigned CMD_SET      = 0;
  localparam int unsigned CMD_RESET    = 1;
  localparam int unsigned CMD_CLR      = 2;
  localparam int unsigned IRQ_LOCK     = 0;
  localparam int unsigned IRQ_UNLOCK   = 1;
  localparam int unsigned IRQ_BAD      = 2;
  localparam int unsigned IRQ_MISS     = 3;
  localparam int unsigned IRQ_W        = 4;
  typedef enum logic [2:0] {
    IN_NONE                      = 3'h0,
    CONNECTOR_PULSE_INPUT_CHOICE = 3'h1,
    IN_HOST                      = 3'h2,
    IN_AUX                       = 3'h3,
    IN_INTERNAL                  = 3'h4
  } tcss_in_e;
  typedef enum logic [2:0] {
    OUT_NONE                     = 3'h0,
    REPEAT_PULSE_OUTPUT_CHOICE   = 3'h1,
    OUT_LOOP                     = 3'h2,
    OUT_HOST                     = 3'h3,
    OUT_MASTER                   = 3'h4
  } tcss_out_e;
endpackage

// File: core/tcss_top.sv
// timestamp clock with selectable sync input and output, Avalon-MM registers
// Operation
// - time loads from host seconds at init, then counts on the local clock
// - a once-per-second pulse on connector circuit A can discipline the clock
// - defaults: input is connector pulse, output drives nothing
// - input choices: none, connector, host, aux, internal host-locked
// - output choices: none, repeat, loop of selected input, host, master
// - set command loads host time, selectors untouched
// - full reset reloads host time, selects connector input, output off
// - phase error against threshold, default 596 ns, gives synced status
// - total, bad and missed pulse counts, cleared by command
// - internal input tracks host clock, drifting with it
// - one card drives master output, the other keeps connector input
// - a valid connector pulse disciplines the clock with no command
// - circuit A carries the pulse, half-duplex; circuit B serial, receive side only
`timescale 1ns/100ps
module tcss_top #(
  parameter int unsigned MISS_CYC      = tcss_pkg::MISS_CYC,
  parameter int unsigned MIN_GAP_CYC   = tcss_pkg::MIN_GAP_CYC,
  parameter int unsigned OUT_PULSE_CYC = tcss_pkg::OUT_PULSE_CYC
) (
  input  wire logic        SYS_CLK,           // 100 MHz clock
  input  wire logic        SYS_RST,           // sync reset, high
  input  wire logic        CE,                // clock enable
  input  wire logic [7:0]  AVS_ADDRESS,       // byte address
  input  wire logic        AVS_READ,          // read request
  input  wire logic        AVS_WRITE,         // write request
  input  wire logic [31:0] AVS_WRITEDATA,     // write data
  input  wire logic [3:0]  AVS_BYTEENABLE,    // byte lanes
  output logic      [31:0] AVS_READDATA,      // read data
  output logic             AVS_WAITREQUEST,   // stall
  input  wire logic        PPS_A_I,           // circuit A pin in
  output logic             PPS_A_O,           // circuit A pin out
  output logic             PPS_A_OE,          // circuit A drive
  input  wire logic        SER_B_I,           // circuit B pin in
  output logic             SER_B_O,           // circuit B pin out
  output logic             SER_B_OE,          // circuit B drive
  input  wire logic        AUX_PPS_I,         // aux pulse pin
  output logic             IRQ                // level interrupt
);
  localparam logic [27:0] MISS_C = 28'(MISS_CYC);
  localparam logic [27:0] GAP_C  = 28'(MIN_GAP_CYC);
  localparam logic [23:0] PULSE_C = 24'(OUT_PULSE_CYC);

  tcss_pkg::tcss_in_e  in_sel;
  tcss_pkg::tcss_out_e out_sel;
  logic [31:0] host_sec, thresh, time_sec, irq_mask;
  logic [31:0] cnt_total, cnt_bad, cnt_missed, cnt_fail, cnt_resync;
  logic [29:0] time_ns;
  logic [27:0] gap_cnt;
  logic [23:0] out_cnt;
  logic [tcss_pkg::IRQ_W-1:0] irq_stat;
  logic [2:0]  pin_a, pin_aux;
  logic [1:0]  pin_b;
  logic        synced, init_done, host_tick;

  // bus handshake: one wait cycle, then the access completes
  logic req, acc, wr_acc, rd_acc;
  assign req    = AVS_READ | AVS_WRITE;
  assign acc    = req & ~AVS_WAITREQUEST;
  assign wr_acc = acc & AVS_WRITE;
  assign rd_acc = acc & AVS_READ;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a[7:2] == ofs[7:2];
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[8*i +: 8] = wd[8*i +: 8];
    return r;
  endfunction

  logic cmd_set, cmd_reset, cmd_clr;
  assign cmd_set   = wr_acc & hit(AVS_ADDRESS, tcss_pkg::OFS_CMD) & AVS_BYTEENABLE[0] & AVS_WRITEDATA[tcss_pkg::CMD_SET];
  assign cmd_reset = wr_acc & hit(AVS_ADDRESS, tcss_pkg::OFS_CMD) & AVS_BYTEENABLE[0] & AVS_WRITEDATA[tcss_pkg::CMD_RESET];
  assign cmd_clr   = wr_acc & hit(AVS_ADDRESS, tcss_pkg::OFS_CMD) & AVS_BYTEENABLE[0] & AVS_WRITEDATA[tcss_pkg::CMD_CLR];
  assign host_tick = wr_acc & hit(AVS_ADDRESS, tcss_pkg::OFS_HOST_SEC);

  always_ff @(posedge SYS_CLK)
    if (SYS_RST)
      AVS_WAITREQUEST <= 1'b1;
    else if (CE)
      AVS_WAITREQUEST <= ~(req & AVS_WAITREQUEST);

  // selectors; only a full reset touches them besides a write
  always_ff @(posedge SYS_CLK)
    if (SYS_RST | (CE & cmd_reset))
    begin
      in_sel  <= tcss_pkg::CONNECTOR_PULSE_INPUT_CHOICE;
      out_sel <= tcss_pkg::OUT_NONE;
    end
    else if (CE & wr_acc & hit(AVS_ADDRESS, tcss_pkg::OFS_SEL) & AVS_BYTEENABLE[0])
    begin
      in_sel  <= tcss_pkg::tcss_in_e'(AVS_WRITEDATA[tcss_pkg::SEL_IN_LSB +: 3]);
      out_sel <= tcss_pkg::tcss_out_e'(AVS_WRITEDATA[tcss_pkg::SEL_OUT_LSB +: 3]);
    end

  always_ff @(posedge SYS_CLK)
    if (SYS_RST)
    begin
      host_sec <= '0;
      thresh   <= tcss_pkg::THRESH_RST;
      irq_mask <= '0;
    end
    else if (CE & wr_acc)
    begin
      if (hit(AVS_ADDRESS, tcss_pkg::OFS_HOST_SEC))
        host_sec <= merge(host_sec, AVS_WRITEDATA, AVS_BYTEENABLE);
      if (hit(AVS_ADDRESS, tcss_pkg::OFS_THRESH))
        thresh <= merge(thresh, AVS_WRITEDATA, AVS_BYTEENABLE);
      if (hit(AVS_ADDRESS, tcss_pkg::OFS_IRQ_MASK))
        irq_mask <= merge(irq_mask, AVS_WRITEDATA, AVS_BYTEENABLE) & 32'h0000000f;
    end

  // pin synchronisers; stage 0 is read only by stage 1
  always_ff @(posedge SYS_CLK)
    if (SYS_RST)
    begin
      pin_a   <= '0;
      pin_aux <= '0;
      pin_b   <= '0;
    end
    else if (CE)
    begin
      pin_a   <= {pin_a[1:0], PPS_A_I};
      pin_aux <= {pin_aux[1:0], AUX_PPS_I};
      pin_b   <= {pin_b[0], SER_B_I};
    end

  logic pin_rise, aux_rise, ref_evt;
  assign pin_rise = pin_a[1] & ~pin_a[2];
  assign aux_rise = pin_aux[1] & ~pin_aux[2];
  // half-duplex: our own drive on circuit A is not taken as a reference
  always_comb
    unique case (in_sel)
      tcss_pkg::CONNECTOR_PULSE_INPUT_CHOICE: ref_evt = pin_rise & ~PPS_A_OE;
      tcss_pkg::IN_INTERNAL:                  ref_evt = host_tick;
      default:                                ref_evt = 1'b0;
    endcase

  // pulse judgement
  logic [29:0] phase_err;
  logic        too_soon, missed, good, bad, late_half, far;
  assign late_half = time_ns >= tcss_pkg::NS_HALF_SEC;
  assign phase_err = late_half ? tcss_pkg::NS_PER_SEC - time_ns : time_ns;
  assign too_soon  = gap_cnt < GAP_C;
  assign missed    = (in_sel != tcss_pkg::IN_NONE) & (gap_cnt == MISS_C) & ~ref_evt;
  assign far       = {2'b00, phase_err} > thresh;
  assign good      = ref_evt & ~too_soon & ~far;
  assign bad       = ref_evt & too_soon;

  always_ff @(posedge SYS_CLK)
    if (SYS_RST)
      gap_cnt <= '0;
    else if (CE)
    begin
      if (ref_evt | (gap_cnt == MISS_C))
        gap_cnt <= '0;
      else
        gap_cnt <= gap_cnt + 28'h0000001;
    end

  // time counter: ns within second and seconds
  logic ns_wrap;
  assign ns_wrap = time_ns >= tcss_pkg::NS_PER_SEC - tcss_pkg::NS_STEP;
  always_ff @(posedge SYS_CLK)
    if (SYS_RST)
    begin
      time_ns   <= '0;
      time_sec  <= '0;
      init_done <= 1'b0;
    end
    else if (CE)
    begin
      if (cmd_set | cmd_reset | (host_tick & ~init_done))
      begin
        time_ns   <= '0;
        time_sec  <= cmd_set | cmd_reset ? host_sec : merge(host_sec, AVS_WRITEDATA, AVS_BYTEENABLE);
        init_done <= 1'b1;
      end
      else if (ref_evt & ~too_soon)
      begin
        time_ns  <= '0;
        time_sec <= time_sec + {31'h00000000, late_half};
      end
      else if (ns_wrap)
      begin
        time_ns  <= '0;
        time_sec <= time_sec + 32'h00000001;
      end
      else
        time_ns <= time_ns + tcss_pkg::NS_STEP;
    end

  always_ff @(posedge SYS_CLK)
    if (SYS_RST | (CE & cmd_reset))
      synced <= 1'b0;
    else if (CE)
    begin
      if (good)
        synced <= 1'b1;
      else if (bad | missed | (ref_evt & far))
        synced <= 1'b0;
    end

  // statistics; an event in the clearing cycle still counts
  always_ff @(posedge SYS_CLK)
    if (SYS_RST)
    begin
      cnt_total  <= '0;
      cnt_bad    <= '0;
      cnt_missed <= '0;
      cnt_fail   <= '0;
      cnt_resync <= '0;
    end
    else if (CE)
    begin
      cnt_total  <= (cmd_clr ? 32'h0 : cnt_total) + {31'h0, ref_evt};
      cnt_bad    <= (cmd_clr ? 32'h0 : cnt_bad) + {31'h0, bad};
      cnt_missed <= (cmd_clr ? 32'h0 : cnt_missed) + {31'h0, missed};
      cnt_fail   <= (cmd_clr ? 32'h0 : cnt_fail) + {31'h0, bad | missed};
      cnt_resync <= (cmd_clr ? 32'h0 : cnt_resync) + {31'h0, ref_evt & ~too_soon & far};
    end

  // interrupt status: set wins over read-clear
  logic [tcss_pkg::IRQ_W-1:0] irq_evt;
  assign irq_evt = {missed, bad, synced & (bad | missed | (ref_evt & far)), good & ~synced};
  always_ff @(posedge SYS_CLK)
    if (SYS_RST)
    begin
      irq_stat <= '0;
      IRQ      <= 1'b0;
    end
    else if (CE)
    begin
      irq_stat <= ((rd_acc & hit(AVS_ADDRESS, tcss_pkg::OFS_IRQ_STAT)) ? '0 : irq_stat) | irq_evt;
      IRQ      <= |(irq_stat & irq_mask[tcss_pkg::IRQ_W-1:0]);
    end

  // output selector and pulse stretcher on circuit A
  logic out_evt;
  always_comb
    unique case (out_sel)
      tcss_pkg::REPEAT_PULSE_OUTPUT_CHOICE: out_evt = pin_rise & (out_cnt == '0);
      tcss_pkg::OUT_LOOP:                   out_evt = ref_evt | (in_sel == tcss_pkg::IN_AUX & aux_rise);
      tcss_pkg::OUT_MASTER:                 out_evt = ns_wrap;
      default:                              out_evt = 1'b0;
    endcase

  always_ff @(posedge SYS_CLK)
    if (SYS_RST)
    begin
      out_cnt  <= '0;
      PPS_A_O  <= 1'b0;
      PPS_A_OE <= 1'b0;
      SER_B_O  <= 1'b0;
      SER_B_OE <= 1'b0;
    end
    else if (CE)
    begin
      if (out_evt)
        out_cnt <= PULSE_C;
      else if (out_cnt != '0)
        out_cnt <= out_cnt - 24'h000001;
      PPS_A_O  <= out_cnt != '0;
      PPS_A_OE <= out_sel != tcss_pkg::OUT_NONE;
      SER_B_O  <= 1'b0; // circuit B serial link not implemented, receive side only
      SER_B_OE <= 1'b0;
    end

  // read data registered in the wait cycle; unmapped reads give zero
  always_ff @(posedge SYS_CLK)
    if (SYS_RST)
      AVS_READDATA <= '0;
    else if (CE & AVS_READ & AVS_WAITREQUEST)
    begin
      AVS_READDATA <= '0;
      if (hit(AVS_ADDRESS, tcss_pkg::OFS_SEL))
        AVS_READDATA <= {25'h0, out_sel, 1'b0, in_sel};
      if (hit(AVS_ADDRESS, tcss_pkg::OFS_HOST_SEC))
        AVS_READDATA <= host_sec;
      if (hit(AVS_ADDRESS, tcss_pkg::OFS_THRESH))
        AVS_READDATA <= thresh;
      if (hit(AVS_ADDRESS, tcss_pkg::OFS_STATUS))
        AVS_READDATA <= {29'h0, pin_b[1], init_done, synced};
      if (hit(AVS_ADDRESS, tcss_pkg::OFS_TOTAL))
        AVS_READDATA <= cnt_total;
      if (hit(AVS_ADDRESS, tcss_pkg::OFS_BAD))
        AVS_READDATA <= cnt_bad;
      if (hit(AVS_ADDRESS, tcss_pkg::OFS_MISSED))
        AVS_READDATA <= cnt_missed;
      if (hit(AVS_ADDRESS, tcss_pkg::OFS_FAIL))
        AVS_READDATA <= cnt_fail;
      if (hit(AVS_ADDRESS, tcss_pkg::OFS_RESYNC))
        AVS_READDATA <= cnt_resync;
      if (hit(AVS_ADDRESS, tcss_pkg::OFS_IRQ_STAT))
        AVS_READDATA <= {28'h0, irq_stat};
      if (hit(AVS_ADDRESS, tcss_pkg::OFS_IRQ_MASK))
        AVS_READDATA <= irq_mask;
      if (hit(AVS_ADDRESS, tcss_pkg::OFS_TIME_NS))
        AVS_READDATA <= {2'b00, time_ns};
      if (hit(AVS_ADDRESS, tcss_pkg::OFS_TIME_SEC))
        AVS_READDATA <= time_sec;
    end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);

  property p_defaults;
    $past(SYS_RST) |-> in_sel == tcss_pkg::CONNECTOR_PULSE_INPUT_CHOICE && out_sel == tcss_pkg::OUT_NONE;
  endproperty
  a_defaults: assert property (p_defaults) else $error("selector defaults wrong");
  property p_set;
    CE && cmd_set |=> time_sec == $past(host_sec) && time_ns == '0 && $stable(in_sel) && $stable(out_sel);
  endproperty
  a_set: assert property (p_set) else $error("set command did not load host time");
  property p_reset;
    CE && cmd_reset |=> in_sel == tcss_pkg::CONNECTOR_PULSE_INPUT_CHOICE && out_sel == tcss_pkg::OUT_NONE
      && time_sec == $past(host_sec) && !synced;
  endproperty
  a_reset: assert property (p_reset) else $error("full reset incomplete");
  property p_advance;
    CE && !cmd_set && !cmd_reset && init_done && !ref_evt && !ns_wrap |=> time_ns == $past(time_ns) + 30'(10);
  endproperty
  a_advance: assert property (p_advance) else $error("time not advancing by one period");
  property p_good_sync;
    CE && good |=> synced;
  endproperty
  a_good_sync: assert property (p_good_sync) else $error("good pulse did not sync");
  property p_count;
    CE && ref_evt && !cmd_clr |=> cnt_total == $past(cnt_total) + 32'h1;
  endproperty
  a_count: assert property (p_count) else $error("pulse not counted");
  property p_clear;
    CE && cmd_clr && !ref_evt && !bad && !missed |=> cnt_total == '0 && cnt_bad == '0 && cnt_fail == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("statistics not cleared");
  property p_fail;
    CE && bad && !cmd_clr |=> cnt_fail == $past(cnt_fail) + 32'h1 && !synced;
  endproperty
  a_fail: assert property (p_fail) else $error("bad pulse not counted as failure");
  property p_hostin;
    in_sel == tcss_pkg::IN_HOST || in_sel == tcss_pkg::IN_NONE |-> !ref_evt;
  endproperty
  a_hostin: assert property (p_hostin) else $error("unused input produced a reference");
  property p_internal;
    CE && in_sel == tcss_pkg::IN_INTERNAL && host_tick && !too_soon && init_done && !cmd_set |=> time_ns == '0;
  endproperty
  a_internal: assert property (p_internal) else $error("host tick did not align time");
  property p_drive;
    CE && out_sel == tcss_pkg::OUT_NONE ##1 CE && out_sel == tcss_pkg::OUT_NONE |-> !PPS_A_OE && !SER_B_OE;
  endproperty
  a_drive: assert property (p_drive) else $error("circuit driven with no output selected");
  property p_master;
    CE && out_sel == tcss_pkg::OUT_MASTER && ns_wrap ##1 CE |=> PPS_A_O && PPS_A_OE;
  endproperty
  a_master: assert property (p_master) else $error("master output pulse missing");
  c_lock:   cover property (CE && good && !synced);
  c_miss:   cover property (CE && missed);
  c_master: cover property (PPS_A_O && out_sel == tcss_pkg::OUT_MASTER);
  c_irq:    cover property ($rose(IRQ));
endmodule // tcss_top

// File: bench/tcss_pps_src.sv
// pulse-per-second source standing on connector circuit A
`timescale 1ns/100ps
module tcss_pps_src #(
  parameter int unsigned PULSE_CYC = 8
) (
  input  wire logic clk,       // bench clock
  input  wire logic fire,      // start one pulse
  input  wire logic released,  // card drives the pair
  output logic      pps,       // level put on circuit A
  output logic      pps_oe     // source drives circuit A
);
  int unsigned cnt = 0;

  always_ff @(posedge clk)
  begin
    if (fire)
      cnt <= PULSE_CYC;
    else if (cnt != 0)
      cnt <= cnt - 1;
  end

  // half-duplex pair: the source lets go while the card drives it
  assign pps_oe = !released;
  assign pps    = (cnt != 0);
endmodule // tcss_pps_src

// File: bench/testbench.sv
// self-checking bench of the timestamp clock sync selector
`timescale 1ns/100ps
module testbench;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic        ser_b_i = 1'b0;
  logic        aux_pps_i = 1'b0;
  logic        fire = 1'b0;
  logic        ce = 1'b1;
  logic [3:0]  avs_byteenable = 4'hf;
  wire  [31:0] avs_readdata;
  wire         avs_waitrequest, pps_a_o, pps_a_oe, ser_b_o, ser_b_oe, irq, pps_drv, pps_oe;
  wire         pps_pin;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  logic [31:0] q, hs, tot0, bad0, res0, mis0, t1;
  int          hi;

  // nobody drives the pair: show a moving level, never a stale one
  assign pps_pin = pps_a_oe ? pps_a_o : (pps_oe ? pps_drv : sys_clk);

  always #5 sys_clk = ~sys_clk;

  tcss_top #(.MISS_CYC(300), .MIN_GAP_CYC(100), .OUT_PULSE_CYC(20)) dut_u (
    .SYS_CLK(sys_clk), .SYS_RST(sys_rst), .CE(ce), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
    .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(avs_byteenable),
    .AVS_READDATA(avs_readdata),
    .AVS_WAITREQUEST(avs_waitrequest), .PPS_A_I(pps_pin), .PPS_A_O(pps_a_o), .PPS_A_OE(pps_a_oe),
    .SER_B_I(ser_b_i), .SER_B_O(ser_b_o), .SER_B_OE(ser_b_oe), .AUX_PPS_I(aux_pps_i), .IRQ(irq));

  tcss_pps_src #(.PULSE_CYC(8)) src_u (
    .clk(sys_clk), .fire(fire), .released(pps_a_oe), .pps(pps_drv), .pps_oe(pps_oe));

  function automatic logic [31:0] sel_val(input logic [2:0] i, input logic [2:0] o);
    return {25'h0, o, 1'b0, i};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // request held until waitrequest is seen low at a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0 && n < 200)
    begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 200)
      n_mismatch++;
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(q & m, e);
  endtask

  task automatic pulse(input int gap);
    @(posedge sys_clk);
    fire <= 1'b1;
    @(posedge sys_clk);
    fire <= 1'b0;
    repeat (gap) @(posedge sys_clk);
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    repeat (60000) @(posedge sys_clk);
    n_mismatch++;
    wrap_up;
  end

  initial
  begin
    void'($urandom(49));
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    rd(tcss_pkg::OFS_SEL, 32'h77, 32'h01);
    chk({31'h0, pps_a_oe}, 32'h0);
    rd(tcss_pkg::OFS_THRESH, 32'hffffffff, tcss_pkg::THRESH_RST);
    rd(tcss_pkg::OFS_STATUS, 32'h2, 32'h0);
    rd(8'hfc, 32'hffffffff, 32'h0);
    wr(8'hfc, 32'hffffffff);
    $display("test reset done");
    hs = $urandom;
    wr(tcss_pkg::OFS_HOST_SEC, hs);
    rd(tcss_pkg::OFS_TIME_SEC, 32'hffffffff, hs);
    rd(tcss_pkg::OFS_STATUS, 32'h2, 32'h2);
    xfer(1'b0, tcss_pkg::OFS_TIME_NS, 32'h0);
    t1 = q;
    repeat (20) @(posedge sys_clk);
    xfer(1'b0, tcss_pkg::OFS_TIME_NS, 32'h0);
    chk({31'h0, q > t1}, 32'h1);
    chk(q - t1, 32'd23 * tcss_pkg::CLK_PERIOD_NS);
    // bus idle while frozen: only three enabled edges lie between the two samples
    t1 = q;
    ce <= 1'b0;
    repeat (40) @(posedge sys_clk);
    ce <= 1'b1;
    xfer(1'b0, tcss_pkg::OFS_TIME_NS, 32'h0);
    chk(q - t1, 32'd3 * tcss_pkg::CLK_PERIOD_NS);
    ser_b_i <= 1'($urandom);
    repeat (6) @(posedge sys_clk);
    rd(tcss_pkg::OFS_STATUS, 32'h4, {29'h0, ser_b_i, 2'h0});
    chk({30'h0, ser_b_o, ser_b_oe}, 32'h0);
    $display("test init done");
    for (int i = 0; i < 5; i++)
    begin
      wr(tcss_pkg::OFS_SEL, sel_val(3'(i), 3'(i)));
      rd(tcss_pkg::OFS_SEL, 32'h77, sel_val(3'(i), 3'(i)));
      repeat (3) @(posedge sys_clk);
      chk({31'h0, pps_a_oe}, {31'h0, i != 0});
    end
    wr(tcss_pkg::OFS_SEL, sel_val(3'h3, 3'h2));
    repeat (3) @(posedge sys_clk);
    hi = 0;
    aux_pps_i <= 1'b1;
    for (int c = 0; c < 65; c++)
    begin
      @(posedge sys_clk);
      hi += pps_a_o;
      if (c == 4)
        aux_pps_i <= 1'b0;
    end
    chk(32'(hi), 32'd20);
    $display("test selectors done");
    wr(tcss_pkg::OFS_SEL, 32'h01);
    avs_byteenable <= 4'h4;
    wr(tcss_pkg::OFS_THRESH, 32'h00010000);
    avs_byteenable <= 4'hf;
    rd(tcss_pkg::OFS_THRESH, 32'hffffffff, 32'h00010000 | tcss_pkg::THRESH_RST);
    // first pulse meets an unknown gap phase, so it is counted before the clear
    pulse(150);
    wr(tcss_pkg::OFS_CMD, 32'h4);
    rd(tcss_pkg::OFS_TOTAL, 32'hffffffff, 32'h0);
    xfer(1'b0, tcss_pkg::OFS_BAD, 32'h0);
    bad0 = q;
    xfer(1'b0, tcss_pkg::OFS_RESYNC, 32'h0);
    res0 = q;
    pulse(10);
    for (int k = 0; k < 4 && q[0] !== 1'b1; k++)
      xfer(1'b0, tcss_pkg::OFS_STATUS, 32'h0);
    chk({31'h0, q[0]}, 32'h1);
    pulse(20);
    rd(tcss_pkg::OFS_STATUS, 32'h1, 32'h0);
    rd(tcss_pkg::OFS_TOTAL, 32'hffffffff, 32'h2);
    rd(tcss_pkg::OFS_BAD, 32'hffffffff, bad0 + 32'h1);
    $display("test lock done");
    wr(tcss_pkg::OFS_THRESH, 32'(tcss_pkg::THRESH_RST));
    repeat (150) @(posedge sys_clk);
    pulse(20);
    rd(tcss_pkg::OFS_RESYNC, 32'hffffffff, res0 + 32'h1);
    rd(tcss_pkg::OFS_STATUS, 32'h1, 32'h0);
    xfer(1'b0, tcss_pkg::OFS_MISSED, 32'h0);
    mis0 = q;
    wr(tcss_pkg::OFS_IRQ_MASK, 32'h8);
    xfer(1'b0, tcss_pkg::OFS_IRQ_STAT, 32'h0);
    repeat (3) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0);
    repeat (320) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h1);
    rd(tcss_pkg::OFS_IRQ_STAT, 32'h8, 32'h8);
    repeat (3) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0);
    rd(tcss_pkg::OFS_MISSED, 32'hffffffff, mis0 + 32'h1);
    wr(tcss_pkg::OFS_IRQ_MASK, 32'h0);
    wr(tcss_pkg::OFS_CMD, 32'h4);
    rd(tcss_pkg::OFS_TOTAL, 32'hffffffff, 32'h0);
    rd(tcss_pkg::OFS_BAD, 32'hffffffff, 32'h0);
    $display("test statistics done");
    hs = $urandom;
    wr(tcss_pkg::OFS_SEL, sel_val(3'h4, 3'h4));
    wr(tcss_pkg::OFS_HOST_SEC, hs);
    wr(tcss_pkg::OFS_CMD, 32'h1);
    rd(tcss_pkg::OFS_TIME_SEC, 32'hffffffff, hs);
    rd(tcss_pkg::OFS_SEL, 32'h77, sel_val(3'h4, 3'h4));
    chk({31'h0, pps_a_oe}, 32'h1);
    wr(tcss_pkg::OFS_CMD, 32'h2);
    rd(tcss_pkg::OFS_SEL, 32'h77, 32'h01);
    rd(tcss_pkg::OFS_TIME_SEC, 32'hffffffff, hs);
    chk({31'h0, pps_a_oe}, 32'h0);
    $display("test commands done");
    wrap_up;
  end
endmodule // testbench
